// *** pcx_pads.sv ***
/*
  Per-pin pad control: driver, open-drain, pull-up, receiver.
  Assumes pin inputs synchronous to the system clock.
*/
`include "pcx_regs.svh"

module pcx_pads
  import pcx_pkg::*;
  #(
  parameter int NPIN = 8
) (
  pcx_xbar_if.pads xb,
  input wire logic xbar_en_i,
  input wire logic pullup_disable_i,
  input wire logic [NPIN-1:0] latch_i,
  input wire logic [NPIN-1:0] in_mode_i,
  input wire logic [NPIN-1:0] out_mode_i,
  input wire pcx_sigvec_t sig_val_i,
  input wire logic [NPIN-1:0] pin_i,
  output logic [NPIN-1:0] pin_o,
  output logic [NPIN-1:0] pin_oe_n_o,
  output logic [NPIN-1:0] pullup_en_o,
  output logic [NPIN-1:0] dig_in_en_o,
  output logic [NPIN-1:0] level_o
);
  // ========================================================
  // Pin cells
  for (genvar p = 0; p < NPIN; p++) begin : g_pin
    wire pcx_sig_e sig = xb.pin_sig[p];
    wire logic digital = in_mode_i[p];
    wire logic val = (sig == PCX_GPIO) ? latch_i[p] : sig_val_i[sig];
    wire logic drives = (sig == PCX_GPIO) || pcx_sig_drives(sig);
    wire logic od = !out_mode_i[p] || pcx_sig_forced_od(sig);
    wire logic enabled = xbar_en_i && digital && drives;
    wire logic pull_low = enabled && !val;
    assign pin_o[p] = od ? 1'b0 : val;
    assign pin_oe_n_o[p] = !(enabled && (!od || pull_low));
    assign pullup_en_o[p] = digital && od && !pullup_disable_i && !pull_low;
    assign dig_in_en_o[p] = digital;
    assign level_o[p] = digital ? pin_i[p] : 1'b1;
  end
endmodule

// *** pcx_pin_board.sv ***
/*
  Board model of the eight port pins: device drive, outside drive, pull-up.
  Assumes active-low output enables; a released pin without pull-up floats.
*/
module pcx_pin_board (
  input wire logic clk_i,
  input wire logic [7:0] drv_i,
  input wire logic [7:0] oe_n_i,
  input wire logic [7:0] pullup_i,
  input wire logic [7:0] ext_en_i,
  input wire logic [7:0] ext_val_i,
  output logic [7:0] level_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] float_r = 8'h5A;

  // ==========================================================
  // Floating pins change every cycle
  always @(posedge clk_i) begin
    float_r <= ~float_r;
  end
  always_comb begin
    for (int n = 0; n < 8; n++) begin
      level_o[n] = !oe_n_i[n] ? drv_i[n] : ext_en_i[n] ? ext_val_i[n] : pullup_i[n] ? 1'h1 : float_r[n];
    end
  end
endmodule

// *** pcx_pkg.sv ***
/*
  Types and small decode functions of the port crossbar.
  Assumes nothing beyond the register header.
*/
package pcx_pkg;
  // ========================================================
  // Pin signal codes, in crossbar priority order after GPIO
  typedef enum logic [3:0] {
    PCX_GPIO, PCX_TX, PCX_RX, PCX_SDA, PCX_SCL, PCX_CP, PCX_CPA, PCX_CLK,
    PCX_CAPTURE_OUT_0, PCX_CAPTURE_OUT_1, PCX_CAPTURE_OUT_2, PCX_ECI, PCX_T0, PCX_T1
  } pcx_sig_e;

  localparam int PCX_NSIG = 14;
  localparam int PCX_NPIN = 8;

  typedef pcx_sig_e [PCX_NPIN-1:0] pcx_pinmap_t;
  typedef logic [PCX_NSIG-1:0] pcx_sigvec_t;

  // ========================================================
  // Signal drives the pin
  function automatic logic pcx_sig_drives(input pcx_sig_e s);
    case (s)
      PCX_RX, PCX_ECI, PCX_T0, PCX_T1: pcx_sig_drives = 1'b0;
      default: pcx_sig_drives = 1'b1;
    endcase
  endfunction

  // ========================================================
  // Signal forces open-drain
  function automatic logic pcx_sig_forced_od(input pcx_sig_e s);
    pcx_sig_forced_od = (s == PCX_SDA) || (s == PCX_SCL);
  endfunction
endpackage

// *** pcx_port_xbar.sv ***
/*
  Port crossbar top: special function registers, routing and pin control.
  Assumes a core special function register port synchronous to sys_clk_i.
*/
`include "pcx_regs.svh"

module pcx_port_xbar
  import pcx_pkg::*;
  (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rmw_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_idx_i,
  input wire logic sfr_bit_wdata_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [7:0] pin_i,
  output logic [7:0] pin_o,
  output logic [7:0] pin_oe_n_o,
  output logic [7:0] pullup_en_o,
  output logic [7:0] dig_in_en_o,
  input wire logic serial_tx_i,
  output logic serial_rx_o,
  input wire logic two_wire_sda_i,
  input wire logic two_wire_scl_i,
  output logic two_wire_sda_o,
  output logic two_wire_scl_o,
  input wire logic compare_out_i,
  input wire logic async_compare_out_i,
  input wire logic [2:0] capture_out_i,
  output logic [2:0] capture_in_o,
  output logic counter_clock_in_o,
  output logic timer0_in_o,
  output logic timer1_in_o
);
  // ========================================================
  // Registers
  logic [7:0] port_latch_r;
  logic [7:0] port_latch_nxt;
  logic [7:0] output_mode_r;
  logic [6:0] crossbar_skip_r;
  logic [7:0] crossbar_route_a_r;
  logic [7:0] crossbar_route_b_r;
  logic [7:0] pin_input_mode_r;
  logic [7:0] sfr_rdata_nxt;
  logic [7:0] level;
  pcx_sigvec_t sig_val;
  pcx_xbar_if xb ();

  // ========================================================
  // Address decode
  wire logic wr_latch = sfr_wr_i && (sfr_addr_i == `PCX_ADDR_PORT_LATCH);
  wire logic wr_out_mode = sfr_wr_i && (sfr_addr_i == `PCX_ADDR_OUT_MODE);
  wire logic wr_skip = sfr_wr_i && (sfr_addr_i == `PCX_ADDR_SKIP);
  wire logic wr_route_a = sfr_wr_i && (sfr_addr_i == `PCX_ADDR_ROUTE_A);
  wire logic wr_route_b = sfr_wr_i && (sfr_addr_i == `PCX_ADDR_ROUTE_B);
  wire logic wr_in_mode = sfr_wr_i && (sfr_addr_i == `PCX_ADDR_IN_MODE);

  // ========================================================
  // Port latch byte and bit writes
  always_comb begin
    port_latch_nxt = port_latch_r;
    if (wr_latch) begin
      port_latch_nxt = sfr_wdata_i;
    end else if (sfr_bit_wr_i) begin
      port_latch_nxt[sfr_bit_idx_i] = sfr_bit_wdata_i;
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      port_latch_r <= `PCX_RST_PORT_LATCH;
    end else begin
      port_latch_r <= port_latch_nxt;
    end
  end

  // ========================================================
  // Configuration registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      output_mode_r <= `PCX_RST_OUT_MODE;
      pin_input_mode_r <= `PCX_RST_IN_MODE;
    end else begin
      if (wr_out_mode) begin
        output_mode_r <= sfr_wdata_i;
      end
      if (wr_in_mode) begin
        pin_input_mode_r <= sfr_wdata_i;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      crossbar_skip_r <= `PCX_RST_SKIP;
      crossbar_route_a_r <= `PCX_RST_ROUTE_A;
      crossbar_route_b_r <= `PCX_RST_ROUTE_B;
    end else begin
      if (wr_skip) begin
        crossbar_skip_r <= sfr_wdata_i[`PCX_SKIP_W-1:0];
      end
      if (wr_route_a) begin
        crossbar_route_a_r <= sfr_wdata_i;
      end
      if (wr_route_b) begin
        crossbar_route_b_r <= sfr_wdata_i & `PCX_B_USED_MASK;
      end
    end
  end

  // ========================================================
  // Signal enables
  wire logic [1:0] cex_field = crossbar_route_a_r[`PCX_A_CEX_HI:`PCX_A_CEX_LO];
  wire logic xbar_en = crossbar_route_b_r[`PCX_B_CROSSBAR_ENABLE];
  wire logic pullup_disable = crossbar_route_b_r[`PCX_B_PULLUP_DISABLE];

  always_comb begin
    xb.sig_en = '0;
    xb.sig_en[PCX_TX] = crossbar_route_a_r[`PCX_A_TX];
    xb.sig_en[PCX_RX] = crossbar_route_a_r[`PCX_A_RX];
    xb.sig_en[PCX_SDA] = crossbar_route_a_r[`PCX_A_TWO_WIRE];
    xb.sig_en[PCX_SCL] = crossbar_route_a_r[`PCX_A_TWO_WIRE];
    xb.sig_en[PCX_CP] = crossbar_route_a_r[`PCX_A_CP];
    xb.sig_en[PCX_CPA] = crossbar_route_a_r[`PCX_A_CPA];
    xb.sig_en[PCX_CLK] = crossbar_route_a_r[`PCX_A_CLK];
    xb.sig_en[PCX_CAPTURE_OUT_0] = cex_field != `PCX_CEX_NONE;
    xb.sig_en[PCX_CAPTURE_OUT_1] = cex_field[1];
    xb.sig_en[PCX_CAPTURE_OUT_2] = cex_field == `PCX_CEX_ALL;
    xb.sig_en[PCX_ECI] = crossbar_route_b_r[`PCX_B_ECI];
    xb.sig_en[PCX_T0] = crossbar_route_b_r[`PCX_B_T0];
    xb.sig_en[PCX_T1] = crossbar_route_b_r[`PCX_B_T1];
  end

  assign xb.skip = crossbar_skip_r;

  // ========================================================
  // Peripheral output values
  always_comb begin
    sig_val = {PCX_NSIG{1'b1}};
    sig_val[PCX_TX] = serial_tx_i;
    sig_val[PCX_SDA] = two_wire_sda_i;
    sig_val[PCX_SCL] = two_wire_scl_i;
    sig_val[PCX_CP] = compare_out_i;
    sig_val[PCX_CPA] = async_compare_out_i;
    sig_val[PCX_CLK] = ~sys_clk_i;
    sig_val[PCX_CAPTURE_OUT_0] = capture_out_i[0];
    sig_val[PCX_CAPTURE_OUT_1] = capture_out_i[1];
    sig_val[PCX_CAPTURE_OUT_2] = capture_out_i[2];
  end

  // ========================================================
  // Decoder and pads
  pcx_route u_route (
    .xb(xb.route)
  );

  pcx_pads #(
    .NPIN(PCX_NPIN)
  ) u_pads (
    .xb(xb.pads),
    .xbar_en_i(xbar_en),
    .pullup_disable_i(pullup_disable),
    .latch_i(port_latch_r),
    .in_mode_i(pin_input_mode_r),
    .out_mode_i(output_mode_r),
    .sig_val_i(sig_val),
    .pin_i(pin_i),
    .pin_o(pin_o),
    .pin_oe_n_o(pin_oe_n_o),
    .pullup_en_o(pullup_en_o),
    .dig_in_en_o(dig_in_en_o),
    .level_o(level)
  );

  // ========================================================
  // Peripheral input return
  function automatic logic level_of(input pcx_sig_e s, input pcx_pinmap_t map,
                                    input logic [7:0] lv, input logic en);
    logic r;
    r = 1'b1;
    for (int p = 0; p < PCX_NPIN; p++) begin
      if (en && map[p] == s) begin
        r = lv[p];
      end
    end
    return r;
  endfunction

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_rx_o <= 1'b1;
      two_wire_sda_o <= 1'b1;
      two_wire_scl_o <= 1'b1;
      capture_in_o <= 3'h7;
      counter_clock_in_o <= 1'b1;
      timer0_in_o <= 1'b1;
      timer1_in_o <= 1'b1;
    end else begin
      serial_rx_o <= level_of(PCX_RX, xb.pin_sig, level, xbar_en);
      two_wire_sda_o <= level_of(PCX_SDA, xb.pin_sig, level, xbar_en);
      two_wire_scl_o <= level_of(PCX_SCL, xb.pin_sig, level, xbar_en);
      capture_in_o[0] <= level_of(PCX_CAPTURE_OUT_0, xb.pin_sig, level, xbar_en);
      capture_in_o[1] <= level_of(PCX_CAPTURE_OUT_1, xb.pin_sig, level, xbar_en);
      capture_in_o[2] <= level_of(PCX_CAPTURE_OUT_2, xb.pin_sig, level, xbar_en);
      counter_clock_in_o <= level_of(PCX_ECI, xb.pin_sig, level, xbar_en);
      timer0_in_o <= level_of(PCX_T0, xb.pin_sig, level, xbar_en);
      timer1_in_o <= level_of(PCX_T1, xb.pin_sig, level, xbar_en);
    end
  end

  // ========================================================
  // Read data
  wire logic [7:0] port_read = sfr_rmw_i ? port_latch_r : level;

  always_comb begin
    case (sfr_addr_i)
      `PCX_ADDR_PORT_LATCH: sfr_rdata_nxt = port_read;
      `PCX_ADDR_OUT_MODE: sfr_rdata_nxt = output_mode_r;
      `PCX_ADDR_SKIP: sfr_rdata_nxt = {1'b0, crossbar_skip_r};
      `PCX_ADDR_ROUTE_A: sfr_rdata_nxt = crossbar_route_a_r;
      `PCX_ADDR_ROUTE_B: sfr_rdata_nxt = crossbar_route_b_r;
      `PCX_ADDR_IN_MODE: sfr_rdata_nxt = pin_input_mode_r;
      default: sfr_rdata_nxt = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= sfr_rdata_nxt;
    end
  end
endmodule

// *** pcx_port_xbar_asserts.sv ***
/*
  Checker of the port crossbar top ports, with shadow copies of its registers.
  Assumes registers change only through the top's register port.
*/
module pcx_port_xbar_asserts (
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_rd_i,
  input wire logic sfr_rmw_i,
  input wire logic sfr_bit_wr_i,
  input wire logic [2:0] sfr_bit_idx_i,
  input wire logic sfr_bit_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [7:0] pin_i,
  input wire logic [7:0] pin_o,
  input wire logic [7:0] pin_oe_n_o,
  input wire logic [7:0] pullup_en_o,
  input wire logic [7:0] dig_in_en_o,
  input wire logic serial_tx_i,
  input wire logic serial_rx_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] lat_r, inm_r, om_r, ra_r, rb_r;
  wire [7:0] pin_view = pin_i | ~inm_r;

  // ==========================================================
  // Shadow registers
  always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_r <= 8'hFF;
      inm_r <= 8'hFF;
      om_r <= 8'h00;
      ra_r <= 8'h00;
      rb_r <= 8'h00;
    end else begin
      if (sfr_bit_wr_i) begin
        lat_r[sfr_bit_idx_i] <= sfr_bit_wdata_i;
      end
      if (sfr_wr_i) begin
        case (sfr_addr_i)
          8'h80: lat_r <= sfr_wdata_i;
          8'hF1: inm_r <= sfr_wdata_i;
          8'hA4: om_r <= sfr_wdata_i;
          8'hE2: ra_r <= sfr_wdata_i;
          8'hE3: rb_r <= sfr_wdata_i;
          default: ;
        endcase
      end
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  sequence s_rd(a);
    sfr_rd_i && !sfr_rmw_i && sfr_addr_i == a;
  endsequence
  sequence s_rmw_rd;
    sfr_rd_i && sfr_rmw_i && sfr_addr_i == 8'h80;
  endsequence
  sequence s_rx_sel;
    rb_r[6] && ra_r[1] && inm_r[5];
  endsequence

  a_analog_pin_off: assert property ((~inm_r & (~pin_oe_n_o | pullup_en_o | dig_in_en_o)) == 8'h00)
    else $error("analog pin not fully off");
  a_xbar_off_hiz: assert property (!rb_r[6] |-> pin_oe_n_o == 8'hFF)
    else $error("driver on with crossbar off");
  a_pullup_off_all: assert property (rb_r[7] |-> pullup_en_o == 8'h00)
    else $error("pull-up on while disabled");
  a_od_pullup_on: assert property (!rb_r[7] |-> (inm_r & ~om_r & pin_oe_n_o & ~pullup_en_o) == 8'h00)
    else $error("released open-drain pin lacks pull-up");
  a_low_no_pullup: assert property ((~pin_oe_n_o & ~pin_o & pullup_en_o) == 8'h00)
    else $error("pull-up on pin driven low");
  a_tx_low_drive: assert property (rb_r[6] && ra_r[0] && inm_r[4] && !serial_tx_i |-> !pin_oe_n_o[4] && !pin_o[4])
    else $error("transmit low not on pin 4");
  a_tx_high_pp: assert property (rb_r[6] && ra_r[0] && om_r[4] && inm_r[4] && serial_tx_i |-> !pin_oe_n_o[4] && pin_o[4])
    else $error("push-pull transmit high not driven");
  a_rx_from_pin: assert property (s_rx_sel |=> serial_rx_o == $past(pin_i[5]))
    else $error("receive input not from pin 5");
  a_rmw_latch_read: assert property (s_rmw_rd |=> sfr_rdata_o == $past(lat_r))
    else $error("modify read not latch");
  a_port_pin_read: assert property (s_rd(8'h80) |=> sfr_rdata_o == $past(pin_view))
    else $error("port read not pin levels");
  a_skip_bit7_zero: assert property (s_rd(8'hE1) |=> !sfr_rdata_o[7])
    else $error("skip bit 7 not zero");
  a_route_b_gap: assert property (s_rd(8'hE3) |=> sfr_rdata_o[5:3] == 3'h0)
    else $error("route B gap bits not zero");
endmodule

bind pcx_port_xbar pcx_port_xbar_asserts pcx_port_xbar_asserts_i (.sys_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i,
  .sfr_wdata_i, .sfr_rd_i, .sfr_rmw_i, .sfr_bit_wr_i, .sfr_bit_idx_i, .sfr_bit_wdata_i, .sfr_rdata_o, .pin_i,
  .pin_o, .pin_oe_n_o, .pullup_en_o, .dig_in_en_o, .serial_tx_i, .serial_rx_o);

// *** pcx_regs.svh ***
/*
  Register addresses, reset values and field positions of the port crossbar.
  Assumes inclusion by bare name from the crossbar pads, top and route modules.
*/
// What this block does
// - Input mode bit set means digital; resets all-ones
// - Analog pin: no pull-up, driver, receiver
// - Two-wire data and clock pins always open-drain
// - Pull-up on open-drain pins unless disabled
// - No pull-up on open-drain pin driving low
// - Crossbar off: all pins inputs, drivers off
// - Skip bit n skips pin n; bit7 zero
// - Capture field routes zero to three outputs
// - Comparator outputs routed only when enabled
// - Inverted system clock routed when enabled
// - Two-wire enable routes both lines together
// - Serial receive fixed on pin 5
// - Serial transmit fixed on pin 4
// - Timer and counter input routing; bits 5-3 zero
// - Port write latches output values; resets ones
// - Port read returns pins; analog reads one
// - Read-modify-write reads latch, not pins
// - Port register byte and bit accessible
// - Output mode applies to peripheral pins too
// - Lowest free unskipped pin per signal, by priority
// - Output mode bit: 0 open-drain, 1 push-pull
`ifndef PCX_REGS_SVH
`define PCX_REGS_SVH

// ==========================================================
// Addresses
`define PCX_ADDR_PORT_LATCH 8'h80
`define PCX_ADDR_OUT_MODE 8'hA4
`define PCX_ADDR_SKIP 8'hE1
`define PCX_ADDR_ROUTE_A 8'hE2
`define PCX_ADDR_ROUTE_B 8'hE3
`define PCX_ADDR_IN_MODE 8'hF1

// ==========================================================
// Reset values
`define PCX_RST_PORT_LATCH 8'hFF
`define PCX_RST_OUT_MODE 8'h00
`define PCX_RST_SKIP 7'h00
`define PCX_RST_ROUTE_A 8'h00
`define PCX_RST_ROUTE_B 8'h00
`define PCX_RST_IN_MODE 8'hFF

// ==========================================================
// Route register A fields
`define PCX_A_TX 0
`define PCX_A_RX 1
`define PCX_A_TWO_WIRE 2
`define PCX_A_CLK 3
`define PCX_A_CP 4
`define PCX_A_CPA 5
`define PCX_A_CEX_HI 7
`define PCX_A_CEX_LO 6

// ==========================================================
// Route register B fields
`define PCX_B_ECI 0
`define PCX_B_T0 1
`define PCX_B_T1 2
`define PCX_B_CROSSBAR_ENABLE 6
`define PCX_B_PULLUP_DISABLE 7
`define PCX_B_USED_MASK 8'hC7

// ==========================================================
// Fixed serial pins, skip width and capture field codes
`define PCX_PIN_TX 4
`define PCX_PIN_RX 5
`define PCX_SKIP_W 7
`define PCX_CEX_NONE 2'h0
`define PCX_CEX_ALL 2'h3

`endif

// *** pcx_route.sv ***
/*
  Priority decoder: fixes transmit on pin 4 and receive on pin 5, then assigns each other enabled signal to a pin while a free unskipped pin remains.
  Assumes enables and skips are stable register outputs.
*/
`include "pcx_regs.svh"

module pcx_route
  import pcx_pkg::*;
  (
  pcx_xbar_if.route xb
);
  // ========================================================
  // Assignment walk
  always_comb begin
    logic [PCX_NPIN-1:0] taken;
    logic [PCX_NPIN-1:0] skipped;
    logic done;
    taken = '0;
    skipped = {1'b0, xb.skip};
    done = 1'b0;
    for (int p = 0; p < PCX_NPIN; p++) begin
      xb.pin_sig[p] = PCX_GPIO;
    end
    if (xb.sig_en[PCX_TX]) begin
      xb.pin_sig[`PCX_PIN_TX] = PCX_TX;
      taken[`PCX_PIN_TX] = 1'b1;
    end
    if (xb.sig_en[PCX_RX]) begin
      xb.pin_sig[`PCX_PIN_RX] = PCX_RX;
      taken[`PCX_PIN_RX] = 1'b1;
    end
    for (int s = int'(PCX_SDA); s < PCX_NSIG; s++) begin
      done = 1'b0;
      if (xb.sig_en[s]) begin
        for (int p = 0; p < PCX_NPIN; p++) begin
          if (!done && !taken[p] && !skipped[p]) begin
            xb.pin_sig[p] = pcx_sig_e'(4'(s));
            taken[p] = 1'b1;
            done = 1'b1;
          end
        end
      end
    end
  end
endmodule

// *** pcx_xbar_if.sv ***
/*
  Carrier between the crossbar register logic, priority decoder and pads.
  Assumes one instance inside the crossbar top module.
*/
interface pcx_xbar_if
  import pcx_pkg::*;
  ();
  pcx_sigvec_t sig_en;
  logic [6:0] skip;
  pcx_pinmap_t pin_sig;

  modport route (input sig_en, input skip, output pin_sig);
  modport ctrl (output sig_en, output skip, input pin_sig);
  modport pads (input pin_sig);
endinterface

// *** port_crossbar_gpio_bench.sv ***
/*
  Self-checking bench of the port crossbar with a pin board model.
  Assumes the checker is bound by its own file.
*/
module port_crossbar_gpio_bench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] sk; logic [7:0] ra; logic [7:0] rb; logic [7:0] oe;} pcx_row_s;
  logic sys_clk_i = 1'h0;
  logic rst_n_i = 1'h0;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'h0;
  logic sfr_rd_i = 1'h0;
  logic sfr_rmw_i = 1'h0;
  logic sfr_bit_wr_i = 1'h0;
  logic [2:0] sfr_bit_idx_i = 3'h0;
  logic sfr_bit_wdata_i = 1'h0;
  logic serial_tx_i = 1'h0;
  logic two_wire_sda_i = 1'h0;
  logic two_wire_scl_i = 1'h0;
  logic compare_out_i = 1'h0;
  logic async_compare_out_i = 1'h0;
  logic [2:0] capture_out_i = 3'h0;
  logic [7:0] ext_en = 8'h00;
  logic [7:0] ext_val = 8'h00;
  logic [7:0] q;
  wire [7:0] sfr_rdata_o, pin_i, pin_o, pin_oe_n_o, pullup_en_o, dig_in_en_o;
  wire serial_rx_o;
  wire two_wire_sda_o, two_wire_scl_o, counter_clock_in_o, timer0_in_o, timer1_in_o;
  wire [2:0] capture_in_o;
  wire [7:0] periph_in = {two_wire_sda_o, two_wire_scl_o, capture_in_o, counter_clock_in_o, timer0_in_o, timer1_in_o};
  int bad_count = 0;
  int checked = 0;
  logic [7:0] ad_t [7] = '{8'h80, 8'hF1, 8'hE1, 8'hE2, 8'hE3, 8'hA4, 8'h55};
  logic [7:0] rv_t [7] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
  pcx_row_s rows [14] = '{'{8'h00, 8'h01, 8'h40, 8'hEF}, '{8'h00, 8'h04, 8'h40, 8'hFC},
    '{8'h00, 8'h05, 8'h40, 8'hEC}, '{8'h00, 8'h07, 8'h40, 8'hEC}, '{8'h44, 8'h34, 8'h40, 8'hE4},
    '{8'h00, 8'hC0, 8'h40, 8'hF8}, '{8'h00, 8'h40, 8'h40, 8'hFE}, '{8'h00, 8'h80, 8'h40, 8'hFC},
    '{8'h7F, 8'h10, 8'h40, 8'h7F}, '{8'h00, 8'h13, 8'h40, 8'hEE}, '{8'h00, 8'h40, 8'h47, 8'hFE},
    '{8'h00, 8'hFF, 8'h00, 8'hFF}, '{8'h10, 8'h01, 8'h40, 8'hEF}, '{8'h03, 8'h34, 8'h40, 8'hC3}};

  pcx_port_xbar pcx_port_xbar_i (.sys_clk_i, .rst_n_i, .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .sfr_rd_i,
    .sfr_rmw_i, .sfr_bit_wr_i, .sfr_bit_idx_i, .sfr_bit_wdata_i, .sfr_rdata_o, .pin_i, .pin_o, .pin_oe_n_o,
    .pullup_en_o, .dig_in_en_o, .serial_tx_i, .serial_rx_o, .two_wire_sda_i, .two_wire_scl_i,
    .two_wire_sda_o, .two_wire_scl_o, .compare_out_i, .async_compare_out_i, .capture_out_i,
    .capture_in_o, .counter_clock_in_o, .timer0_in_o, .timer1_in_o);
  pcx_pin_board pcx_pin_board_i (.clk_i(sys_clk_i), .drv_i(pin_o), .oe_n_i(pin_oe_n_o),
    .pullup_i(pullup_en_o), .ext_en_i(ext_en), .ext_val_i(ext_val), .level_o(pin_i));

  always #20 sys_clk_i = ~sys_clk_i;

  // ==========================================================
  // Register port and compare tasks
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'h1;
    @(negedge sys_clk_i);
    sfr_wr_i = 1'h0;
  endtask
  task automatic rd(input logic [7:0] a, input logic m, output logic [7:0] v);
    @(negedge sys_clk_i);
    sfr_addr_i = a;
    sfr_rmw_i = m;
    sfr_rd_i = 1'h1;
    @(negedge sys_clk_i);
    sfr_rd_i = 1'h0;
    sfr_rmw_i = 1'h0;
    v = sfr_rdata_o;
  endtask
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("TB: checked=%0d bad_count=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 20000; i++) @(posedge sys_clk_i);
    bad_count++;
    print_verdict();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(negedge sys_clk_i);
    rst_n_i = 1'h1;
    chk(pin_oe_n_o, 8'hFF);
    chk(dig_in_en_o, 8'hFF);
    chk(pullup_en_o, 8'hFF);
    chk(periph_in, 8'hFF);
    for (int i = 0; i < 7; i++) begin
      rd(ad_t[i], i == 0, q);
      chk(q, rv_t[i]);
    end
    $display("TB: reset test done");
    wr(8'hE1, 8'hFF);
    rd(8'hE1, 1'h0, q);
    chk(q, 8'h7F);
    wr(8'hE3, 8'hFF);
    rd(8'hE3, 1'h0, q);
    chk(q, 8'hC7);
    $display("TB: refused bits test done");
    wr(8'hE3, 8'h00);
    wr(8'hF1, 8'hFF);
    wr(8'hA4, 8'h00);
    foreach (rows[i]) begin
      wr(8'hE1, rows[i].sk);
      wr(8'hE2, rows[i].ra);
      wr(8'hE3, rows[i].rb);
      chk(pin_oe_n_o, rows[i].oe);
    end
    $display("TB: routing table done");
    wr(8'hE2, 8'h00);
    wr(8'hE1, 8'h00);
    wr(8'hA4, 8'h0F);
    wr(8'hE3, 8'h40);
    wr(8'h80, 8'h5A);
    chk(pin_oe_n_o, 8'h50);
    chk(pin_o, 8'h0A);
    chk(pullup_en_o, 8'h50);
    rd(8'h80, 1'h0, q);
    chk(q, 8'h5A);
    ext_en = 8'h40;
    rd(8'h80, 1'h0, q);
    chk(q, 8'h1A);
    rd(8'h80, 1'h1, q);
    chk(q, 8'h5A);
    @(negedge sys_clk_i);
    sfr_bit_idx_i = 3'h1;
    sfr_bit_wr_i = 1'h1;
    @(negedge sys_clk_i);
    sfr_bit_wr_i = 1'h0;
    chk(pin_o, 8'h08);
    wr(8'hF1, 8'hFB);
    chk(dig_in_en_o, 8'hFB);
    chk(pin_oe_n_o, 8'h54);
    rd(8'h80, 1'h0, q);
    chk(q, 8'h1C);
    wr(8'hE3, 8'hC0);
    chk(pullup_en_o, 8'h00);
    ext_en = 8'h00;
    wr(8'hF1, 8'hFF);
    $display("TB: port latch test done");
    wr(8'hA4, 8'hFF);
    wr(8'h80, 8'hFF);
    wr(8'hE2, 8'h05);
    wr(8'hE3, 8'h40);
    serial_tx_i = 1'h1;
    two_wire_sda_i = 1'h1;
    two_wire_scl_i = 1'h1;
    #1;
    chk(pin_oe_n_o, 8'h03);
    chk(pin_o, 8'hFC);
    $display("TB: output mode test done");
    wr(8'hE2, 8'h02);
    ext_en = 8'h20;
    @(negedge sys_clk_i);
    chk({7'h00, serial_rx_o}, 8'h00);
    ext_val = 8'h20;
    @(negedge sys_clk_i);
    chk({7'h00, serial_rx_o}, 8'h01);
    wr(8'hE2, 8'h08);
    #1;
    chk(pin_o, 8'hFF);
    @(posedge sys_clk_i);
    #1;
    chk(pin_o, 8'hFE);
    $display("TB: receive and clock test done");
    wr(8'hE2, 8'hC4);
    wr(8'hE3, 8'h47);
    capture_out_i = 3'h5;
    ext_en = 8'hE3;
    ext_val = 8'h62;
    @(negedge sys_clk_i);
    chk(periph_in, 8'h6E);
    $display("TB: peripheral input test done");
    print_verdict();
  end
endmodule
